// ==== core/ctxt_pkg.sv ====
// Package for the continuous transmit test block: register offsets,
// reset values, command codes, state readback codes and timing.
// Assumes an 8-bit register port and a 128-byte frame buffer.
package ctxt_pkg;
    // Register offsets on the register port
    localparam logic [5:0] CTXT_ADDR_STATE      = 6'h01;
    localparam logic [5:0] CTXT_ADDR_COMMAND    = 6'h02;
    localparam logic [5:0] CTXT_ADDR_CLKOUT     = 6'h03;
    localparam logic [5:0] CTXT_ADDR_TX_CTRL    = 6'h04;
    localparam logic [5:0] CTXT_ADDR_TX_POWER   = 6'h05;
    localparam logic [5:0] CTXT_ADDR_CHANNEL    = 6'h08;
    localparam logic [5:0] CTXT_ADDR_HR_CFG     = 6'h0a;
    localparam logic [5:0] CTXT_ADDR_RATE       = 6'h0c;
    localparam logic [5:0] CTXT_ADDR_IRQ_MASK   = 6'h0e;
    localparam logic [5:0] CTXT_ADDR_IRQ_STATUS = 6'h0f;
    localparam logic [5:0] CTXT_ADDR_UNLOCK     = 6'h1c;
    localparam logic [5:0] CTXT_ADDR_TEST_EN    = 6'h36;
    // Reset values
    localparam logic [7:0] CTXT_RST_COMMAND  = 8'h00;
    localparam logic [7:0] CTXT_RST_CLKOUT   = 8'h19;
    localparam logic [7:0] CTXT_RST_TX_CTRL  = 8'h20;
    localparam logic [7:0] CTXT_RST_TX_POWER = 8'hc0;
    localparam logic [7:0] CTXT_RST_CHANNEL  = 8'h2b;
    localparam logic [7:0] CTXT_RST_HR_CFG   = 8'hb7;
    localparam logic [7:0] CTXT_RST_RATE     = 8'h00;
    localparam logic [7:0] CTXT_RST_IRQ_MASK = 8'h00;
    localparam logic [7:0] CTXT_RST_UNLOCK   = 8'h03;
    localparam logic [7:0] CTXT_RST_TEST_EN  = 8'h00;
    // Command codes written to the command register
    localparam logic [7:0] CTXT_CMD_TX_START = 8'h02;
    localparam logic [7:0] CTXT_CMD_IDLE     = 8'h03;
    localparam logic [7:0] CTXT_CMD_PLL_ON   = 8'h09;
    // State readback codes
    localparam logic [7:0] CTXT_ST_RESET     = 8'h00;
    localparam logic [7:0] CTXT_ST_IDLE      = 8'h08;
    localparam logic [7:0] CTXT_ST_PLL_ON    = 8'h09;
    localparam logic [7:0] CTXT_ST_BUSY_TX   = 8'h02;
    // Enable sequence values and field layout
    localparam logic [7:0] CTXT_UNLOCK_KEY1  = 8'h54;
    localparam logic [7:0] CTXT_UNLOCK_KEY2  = 8'h46;
    localparam logic [7:0] CTXT_UNLOCK_OFF   = 8'h00;
    localparam logic [3:0] CTXT_TEST_ON      = 4'hf;
    localparam int         CTXT_IRQ_LOCK_BIT = 0;
    // CW mode selection values
    localparam logic [7:0] CTXT_RATE_2M      = 8'h03;
    localparam logic [7:0] CTXT_HR_CW        = 8'ha7;
    // Byte fill values that pick the tone side
    localparam logic [7:0] CTXT_FILL_LOW     = 8'h00;
    localparam logic [7:0] CTXT_FILL_HIGH    = 8'hff;
    // Synthesizer settle time and its count at 250 MHz
    localparam int         CTXT_LOCK_TIME_NS = 64;
    localparam int         CTXT_CLK_MHZ      = 250;
    localparam int         CTXT_LOCK_CYCLES  = (CTXT_LOCK_TIME_NS * CTXT_CLK_MHZ + 999) / 1000;
    // Transceiver states
    typedef enum logic [1:0] {CTXT_S_RESET, CTXT_S_IDLE, CTXT_S_PLL_ON, CTXT_S_BUSY_TX} ctxt_state_t;
    // Enable sequence stages
    typedef enum logic [1:0] {CTXT_U_OFF, CTXT_U_KEY1, CTXT_U_ON} ctxt_unlock_t;
endpackage

// ==== core/ctxt_core.sv ====
// Continuous transmit test block: register file, transceiver state,
// synthesizer lock, enable sequence and endless PSDU streaming.
// Assumes host logic on clk drives the register and frame buffer
// ports, and the transmit link runs on its own clock tx_clk.
`timescale 1ns/1ps

module ctxt_core
    import ctxt_pkg::*;
#(
    parameter int LOCK_CYCLES = CTXT_LOCK_CYCLES  // Synthesizer settle count
) (
    input  wire logic       clk,           // Core clock, 250 MHz
    input  wire logic       rst_b,         // Asynchronous reset, active low
    input  wire logic       reg_we,        // Register write strobe
    input  wire logic       reg_re,        // Register read strobe
    input  wire logic [5:0] reg_addr,      // Register offset
    input  wire logic [7:0] reg_wdata,     // Register write data
    output logic      [7:0] reg_rdata_q,   // Register read data
    output logic            reg_rvalid_q,  // Read data valid pulse
    input  wire logic       fb_we,         // Frame buffer write strobe
    input  wire logic [6:0] fb_addr,       // Frame buffer byte index
    input  wire logic [7:0] fb_wdata,      // Frame buffer write data
    output logic            irq_q,         // Masked interrupt level
    output logic            test_on_q,     // Continuous mode active
    output logic            cw_mode_q,     // Unmodulated tone selected
    output logic            tone_up_q,     // Tone above channel centre
    output logic            tone_down_q,   // Tone below channel centre
    input  wire logic       tx_clk,        // Transmit link clock
    input  wire logic       tx_ready,      // Link accepts a byte
    output logic      [7:0] tx_byte_q,     // Byte on the link
    output logic            tx_valid_q     // Byte valid on the link
);
    localparam int FB_DEPTH = 128;

    // Configuration registers
    logic [7:0]   command_q;        // Last command written
    logic [7:0]   clkout_q;         // Clock output control
    logic [7:0]   tx_ctrl_q;        // Transmit control
    logic [7:0]   tx_power_q;       // Output power
    logic [7:0]   channel_q;        // Channel select
    logic [7:0]   hr_cfg_q;         // High rate configuration
    logic [7:0]   rate_q;           // Data rate select
    logic [7:0]   irq_mask_q;       // Interrupt enable mask
    logic [7:0]   irq_status_q;     // Pending interrupt bits
    logic [7:0]   unlock_q;         // Unlock register image
    logic [7:0]   test_en_q;        // Test control register
    ctxt_state_t  state_q;          // Transceiver state
    ctxt_unlock_t unlock_st_q;      // Enable sequence stage
    logic [15:0]  lock_cnt_q;       // Synthesizer settle counter
    logic         locked_q;         // Synthesizer locked
    logic         lock_evt;         // Lock reached this cycle
    logic [7:0]   fb_mem [FB_DEPTH]; // Frame buffer storage
    logic         all_low_q;        // Every PSDU byte is 0x00
    logic         all_high_q;       // Every PSDU byte is 0xFF
    logic [6:0]   rd_ptr_q;         // PSDU read index
    logic [6:0]   psdu_len;         // PSDU length, at least one
    logic         streaming;        // Stream bytes into buffer

    // Write decode helper
    function automatic logic hit(input logic we, input logic [5:0] a, input logic [5:0] off);
        hit = we && (a == off);
    endfunction

    // Configuration register writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            command_q  <= CTXT_RST_COMMAND;
            clkout_q   <= CTXT_RST_CLKOUT;
            tx_ctrl_q  <= CTXT_RST_TX_CTRL;
            tx_power_q <= CTXT_RST_TX_POWER;
            channel_q  <= CTXT_RST_CHANNEL;
            hr_cfg_q   <= CTXT_RST_HR_CFG;
            rate_q     <= CTXT_RST_RATE;
            irq_mask_q <= CTXT_RST_IRQ_MASK;
            unlock_q   <= CTXT_RST_UNLOCK;
            test_en_q  <= CTXT_RST_TEST_EN;
        end else begin
            if (hit(reg_we, reg_addr, CTXT_ADDR_COMMAND))  command_q  <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_CLKOUT))   clkout_q   <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_TX_CTRL))  tx_ctrl_q  <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_TX_POWER)) tx_power_q <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_CHANNEL))  channel_q  <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_HR_CFG))   hr_cfg_q   <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_RATE))     rate_q     <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_IRQ_MASK)) irq_mask_q <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_UNLOCK))   unlock_q   <= reg_wdata;
            if (hit(reg_we, reg_addr, CTXT_ADDR_TEST_EN))  test_en_q  <= reg_wdata;
        end
    end

    // Enable sequence: 0x0F in test control, then 0x54, 0x46 to unlock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            unlock_st_q <= CTXT_U_OFF;
        end else if (test_en_q[3:0] != CTXT_TEST_ON) begin
            unlock_st_q <= CTXT_U_OFF;  // Test control not armed
        end else if (hit(reg_we, reg_addr, CTXT_ADDR_UNLOCK)) begin
            case (unlock_st_q)
                CTXT_U_OFF: begin
                    // First key only counts after arming
                    unlock_st_q <= (reg_wdata == CTXT_UNLOCK_KEY1) ? CTXT_U_KEY1 : CTXT_U_OFF;
                end
                CTXT_U_KEY1: begin
                    // Second key must follow directly
                    unlock_st_q <= (reg_wdata == CTXT_UNLOCK_KEY2) ? CTXT_U_ON : CTXT_U_OFF;
                end
                CTXT_U_ON: begin
                    // Writing 0x00 ends the
                    if (reg_wdata == CTXT_UNLOCK_OFF) unlock_st_q <= CTXT_U_OFF;
                end
                default: unlock_st_q <= CTXT_U_OFF;
            endcase
        end
    end

    // Transceiver state from commands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= CTXT_S_RESET;
        end else if (hit(reg_we, reg_addr, CTXT_ADDR_COMMAND)) begin
            case (reg_wdata)
                CTXT_CMD_IDLE:   state_q <= CTXT_S_IDLE;  // Idle request
                CTXT_CMD_PLL_ON: state_q <= CTXT_S_PLL_ON;  // Synthesizer on
                CTXT_CMD_TX_START: begin
                    // Start only once the synthesizer is locked
                    if (state_q == CTXT_S_PLL_ON && locked_q) state_q <= CTXT_S_BUSY_TX;
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // Synthesizer settle counter, lock event fires once per PLL_ON
    assign lock_evt = (state_q == CTXT_S_PLL_ON) && !locked_q && (lock_cnt_q == 16'(LOCK_CYCLES - 1));
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end else if (state_q == CTXT_S_PLL_ON || state_q == CTXT_S_BUSY_TX) begin
            if (lock_evt) begin
                locked_q <= 1'b1;  // Lock reached
            end else if (!locked_q) begin
                lock_cnt_q <= lock_cnt_q + 16'h0001;
            end
        end else begin
            lock_cnt_q <= '0;  // Synthesizer off, lose lock
            locked_q   <= 1'b0;
        end
    end

    // Interrupt status: set by lock, cleared by read, set wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_q <= '0;
        end else begin
            if (hit(reg_re, reg_addr, CTXT_ADDR_IRQ_STATUS)) irq_status_q <= '0;
            if (lock_evt) irq_status_q[CTXT_IRQ_LOCK_BIT] <= 1'b1;  // Lock event
        end
    end

    // Interrupt line follows masked status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) irq_q <= 1'b0;
        else        irq_q <= |(irq_status_q & irq_mask_q);  // Only unmasked events
    end

    // Register read path, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q  <= '0;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_re;
            if (reg_re) begin
                case (reg_addr)
                    CTXT_ADDR_STATE: begin
                        case (state_q)
                            CTXT_S_IDLE:    reg_rdata_q <= CTXT_ST_IDLE;  // Idle reads 0x08
                            CTXT_S_PLL_ON:  reg_rdata_q <= CTXT_ST_PLL_ON;
                            CTXT_S_BUSY_TX: reg_rdata_q <= CTXT_ST_BUSY_TX;
                            default:        reg_rdata_q <= CTXT_ST_RESET;
                        endcase
                    end
                    CTXT_ADDR_COMMAND:    reg_rdata_q <= command_q;
                    CTXT_ADDR_CLKOUT:     reg_rdata_q <= clkout_q;
                    CTXT_ADDR_TX_CTRL:    reg_rdata_q <= tx_ctrl_q;
                    CTXT_ADDR_TX_POWER:   reg_rdata_q <= tx_power_q;
                    CTXT_ADDR_CHANNEL:    reg_rdata_q <= channel_q;
                    CTXT_ADDR_HR_CFG:     reg_rdata_q <= hr_cfg_q;
                    CTXT_ADDR_RATE:       reg_rdata_q <= rate_q;
                    CTXT_ADDR_IRQ_MASK:   reg_rdata_q <= irq_mask_q;
                    CTXT_ADDR_IRQ_STATUS: reg_rdata_q <= irq_status_q;  // Lock shows 0x01
                    CTXT_ADDR_UNLOCK:     reg_rdata_q <= unlock_q;
                    CTXT_ADDR_TEST_EN:    reg_rdata_q <= {4'h0, test_en_q[3:0]};  // Reserved read zero
                    default:              reg_rdata_q <= '0;  // Unmapped offset
                endcase
            end
        end
    end

    // Frame buffer storage and fill tracking for the tone side
    always_ff @(posedge clk) begin
        if (fb_we) fb_mem[fb_addr] <= fb_wdata;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            all_low_q  <= 1'b1;
            all_high_q <= 1'b1;
        end else if (fb_we) begin
            if (fb_addr == 7'h00) begin
                all_low_q  <= 1'b1;  // New PHR starts a new frame
                all_high_q <= 1'b1;
            end else begin
                all_low_q  <= all_low_q && (fb_wdata == CTXT_FILL_LOW);
                all_high_q <= all_high_q && (fb_wdata == CTXT_FILL_HIGH);
            end
        end
    end

    // Mode outputs: CW picked by rate and high rate setting
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            test_on_q   <= 1'b0;
            cw_mode_q   <= 1'b0;
            tone_up_q   <= 1'b0;
            tone_down_q <= 1'b0;
        end else begin
            test_on_q   <= streaming;
            cw_mode_q   <= streaming && rate_q == CTXT_RATE_2M && hr_cfg_q == CTXT_HR_CW;
            // Tone side from fill, neither side for mixed fill
            tone_up_q   <= streaming && rate_q == CTXT_RATE_2M && hr_cfg_q == CTXT_HR_CW && all_high_q;
            tone_down_q <= streaming && rate_q == CTXT_RATE_2M && hr_cfg_q == CTXT_HR_CW && all_low_q;
        end
    end

    // PSDU streaming from index 1, skipping the header byte at index 0
    assign psdu_len  = (fb_mem[0][6:0] == 7'h00) ? 7'h01 : fb_mem[0][6:0];
    assign streaming = (unlock_st_q == CTXT_U_ON) && (state_q == CTXT_S_BUSY_TX);

    // Two-entry crossing buffer, gray pointers
    logic [7:0] buf_mem [2];  // Buffer entries
    logic [1:0] wbin_q;       // Write pointer, binary
    logic [1:0] wgray_q;      // Write pointer, gray
    logic [1:0] rgray_s1_q;   // Read pointer, first stage
    logic [1:0] rgray_s2_q;   // Read pointer, synchronised
    logic [1:0] rbin_q;       // Read pointer, binary
    logic [1:0] rgray_q;      // Read pointer, gray
    logic [1:0] wgray_s1_q;   // Write pointer, first stage
    logic [1:0] wgray_s2_q;   // Write pointer, synchronised
    logic       buf_full;     // No room for a byte
    logic       buf_empty;    // Nothing to send
    logic       push;         // Byte enters buffer
    logic       pop;          // Byte leaves buffer
    logic [1:0] wbin_nx;      // Next write pointer
    logic [1:0] rbin_nx;      // Next read pointer

    assign buf_full  = (wgray_q == ~rgray_s2_q);
    assign buf_empty = (rgray_q == wgray_s2_q);
    assign push      = streaming && !buf_full;  // Stall holds position, no byte lost
    assign wbin_nx   = wbin_q + 2'b01;
    assign pop       = !buf_empty && (!tx_valid_q || tx_ready);
    assign rbin_nx   = rbin_q + 2'b01;

    // Write side: fill buffer and advance PSDU index
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wbin_q   <= '0;
            wgray_q  <= '0;
            rd_ptr_q <= 7'h01;
        end else if (!streaming) begin
            rd_ptr_q <= 7'h01;  // Next run starts at first PSDU byte
        end else if (push) begin
            wbin_q   <= wbin_nx;
            wgray_q  <= wbin_nx ^ {1'b0, wbin_nx[1]};
            // Wrap after the last byte with no gap
            rd_ptr_q <= (rd_ptr_q >= psdu_len) ? 7'h01 : rd_ptr_q + 7'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (push) buf_mem[wbin_q[0]] <= fb_mem[rd_ptr_q];
    end

    // Read pointer into the core domain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rgray_s1_q <= '0;
            rgray_s2_q <= '0;
        end else begin
            rgray_s1_q <= rgray_q;
            rgray_s2_q <= rgray_s1_q;
        end
    end

    // Write pointer into the link domain
    always_ff @(posedge tx_clk or negedge rst_b) begin
        if (!rst_b) begin
            wgray_s1_q <= '0;
            wgray_s2_q <= '0;
        end else begin
            wgray_s1_q <= wgray_q;
            wgray_s2_q <= wgray_s1_q;
        end
    end

    // Link side: drain buffer, hold byte while the link stalls
    always_ff @(posedge tx_clk or negedge rst_b) begin
        if (!rst_b) begin
            rbin_q     <= '0;
            rgray_q    <= '0;
            tx_byte_q  <= '0;
            tx_valid_q <= 1'b0;
        end else if (pop) begin
            rbin_q     <= rbin_nx;
            rgray_q    <= rbin_nx ^ {1'b0, rbin_nx[1]};
            tx_byte_q  <= buf_mem[rbin_q[0]];  // Continuous byte stream
            tx_valid_q <= 1'b1;
        end else if (tx_ready) begin
            tx_valid_q <= 1'b0;  // Taken, nothing new
        end
    end
endmodule

// ==== verif/ctxt_core_asserts.sv ====
// Checker for the continuous transmit core: register port and link.
// Bound onto ctxt_core from the testbench top file.
`timescale 1ns/1ps
module ctxt_core_asserts
    import ctxt_pkg::*;
(
    input wire logic       clk,          // Core clock
    input wire logic       rst_b,        // Reset, low
    input wire logic       reg_we,       // Write strobe
    input wire logic       reg_re,       // Read strobe
    input wire logic [5:0] reg_addr,     // Offset
    input wire logic [7:0] reg_wdata,    // Write data
    input wire logic [7:0] reg_rdata_q,  // Read data
    input wire logic       reg_rvalid_q, // Read valid
    input wire logic       test_on_q,    // Streaming
    input wire logic       cw_mode_q,    // Tone mode
    input wire logic       tone_up_q,    // Upper tone
    input wire logic       tone_down_q,  // Lower tone
    input wire logic       tx_clk,       // Link clock
    input wire logic       tx_ready,     // Link ready
    input wire logic [7:0] tx_byte_q,    // Link byte
    input wire logic       tx_valid_q    // Link valid
);
    AST_RVALID: assert property (@(posedge clk) disable iff (!rst_b) reg_re |=> reg_rvalid_q)
        else $error("read answer missing");
    AST_NO_SPUR: assert property (@(posedge clk) disable iff (!rst_b) !reg_re |=> !reg_rvalid_q)
        else $error("read answer without strobe");
    AST_TEST_HI: assert property (@(posedge clk) disable iff (!rst_b)
        reg_re && reg_addr == CTXT_ADDR_TEST_EN |=> reg_rdata_q[7:4] == 4'h0)
        else $error("test control upper bits not zero");
    AST_CW_ON: assert property (@(posedge clk) disable iff (!rst_b) cw_mode_q |-> test_on_q)
        else $error("tone mode without streaming");
    AST_TONE_EXCL: assert property (@(posedge clk) disable iff (!rst_b) tone_up_q |-> !tone_down_q)
        else $error("both tones at once");
    AST_TONE_CW: assert property (@(posedge clk) disable iff (!rst_b)
        tone_up_q || tone_down_q |-> cw_mode_q)
        else $error("tone flag outside tone mode");
    AST_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        reg_we && reg_addr == CTXT_ADDR_UNLOCK && reg_wdata == 8'h00 && test_on_q |-> ##[1:2] !test_on_q)
        else $error("disable write did not stop streaming");
    AST_HOLD: assert property (@(posedge tx_clk) disable iff (!rst_b)
        tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_byte_q))
        else $error("link byte changed while stalled");
endmodule

// ==== verif/ctxt_link_sink.sv ====
// Link receiver model: takes bytes, optionally stalling.
// Assumes the core offers bytes on tx_clk.
`timescale 1ns/1ps
module ctxt_link_sink (
    input  wire logic tx_clk,     // Link clock
    input  wire logic rst_b,      // Reset, low
    input  wire logic tx_valid_q, // Byte offered
    input  wire logic stall,      // Slow receiver
    output logic      tx_ready,   // Accepting
    output logic      take        // Transfer now
);
    logic [1:0] cnt_q; // Stall phase
    // Ready moves on the falling edge, away from sampling
    always @(negedge tx_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q    <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            cnt_q    <= cnt_q + 2'h1;
            tx_ready <= !stall || cnt_q == 2'h3;
        end
    end
    assign take = tx_valid_q && tx_ready;
endmodule

// ==== verif/test_ctxt_core.sv ====
// Testbench for the continuous transmit core: enable sequence in both
// modes, stream compared with a queue model. Assumes ctxt_pkg first.
`timescale 1ns/1ps
module test_ctxt_core;
    import ctxt_pkg::*;
    logic        clk, rst_b, tx_clk, stall, reg_we, reg_re, fb_we;  // Drives
    logic [5:0]  reg_addr;                                          // Offset
    logic [6:0]  fb_addr;                                           // Index
    logic [7:0]  reg_wdata, fb_wdata, reg_rdata_q, tx_byte_q;       // Data
    logic        reg_rvalid_q, irq_q, test_on_q, cw_mode_q;         // Flags
    logic        tone_up_q, tone_down_q, tx_ready, tx_valid_q, take; // Flags
    logic [16:0] lfsr_q;                                            // Random
    int          error_cnt, n_compared;                             // Counts
    logic [7:0]  psdu[$], got[$];                                   // Model
    ctxt_core #(.LOCK_CYCLES(4)) DUT (.clk(clk), .rst_b(rst_b), .reg_we(reg_we), .reg_re(reg_re),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .fb_we(fb_we), .fb_addr(fb_addr), .fb_wdata(fb_wdata), .irq_q(irq_q), .test_on_q(test_on_q),
        .cw_mode_q(cw_mode_q), .tone_up_q(tone_up_q), .tone_down_q(tone_down_q), .tx_clk(tx_clk),
        .tx_ready(tx_ready), .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q));
    ctxt_link_sink SINK (.tx_clk(tx_clk), .rst_b(rst_b), .tx_valid_q(tx_valid_q), .stall(stall),
        .tx_ready(tx_ready), .take(take));
    // Clocks: 4 ns core, 6 ns link with a phase offset
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        tx_clk = 1'b0;
        #1.3;
        forever #3 tx_clk = ~tx_clk;
    end
    // Collect every byte taken on the link
    always @(posedge tx_clk) begin
        if (take === 1'b1) got.push_back(tx_byte_q);
    end
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Register and buffer strobes: one cycle each, driven on falling edges
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_we = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_we = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_re = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_re = 1'b0;
        chk(reg_rdata_q, e);
    endtask
    task automatic fbw(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        fb_we = 1'b1;
        fb_addr = a;
        fb_wdata = d;
        @(negedge clk);
        fb_we = 1'b0;
    endtask
    // One full test run: reset, configure, load, enable, stream, disable
    task automatic run(input logic cw, input int kind);
        int   len;
        int   k;
        logic up;
        logic dn;
        rst_b = 1'b0;
        stall = kind[0];
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        got.delete();
        psdu.delete();
        rd(CTXT_ADDR_STATE, CTXT_ST_RESET);
        rd(CTXT_ADDR_UNLOCK, CTXT_RST_UNLOCK);
        rd(6'h3f, 8'h00);
        wr(CTXT_ADDR_IRQ_MASK, 8'h01);
        wr(CTXT_ADDR_TX_CTRL, 8'h00);
        wr(CTXT_ADDR_COMMAND, CTXT_CMD_IDLE);
        wr(CTXT_ADDR_CLKOUT, 8'h01);
        wr(CTXT_ADDR_CHANNEL, 8'h33);
        wr(CTXT_ADDR_TX_POWER, 8'h00);
        rd(CTXT_ADDR_STATE, CTXT_ST_IDLE);
        wr(CTXT_ADDR_TEST_EN, 8'h0f);
        rd(CTXT_ADDR_TEST_EN, 8'h0f);
        if (cw) begin
            wr(CTXT_ADDR_RATE, CTXT_RATE_2M);
            wr(CTXT_ADDR_HR_CFG, CTXT_HR_CW);
        end
        lfsr_q = lfsr_next(lfsr_q);
        len = cw ? 2 + lfsr_q[2:0] : 127;
        fbw(7'h00, len[7:0]);
        for (k = 1; k <= len; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            psdu.push_back(kind == 1 ? CTXT_FILL_LOW : kind == 2 ? CTXT_FILL_HIGH : lfsr_q[7:0]);
            fbw(k[6:0], psdu[k-1]);
        end
        up = 1'b1;
        dn = 1'b1;
        foreach (psdu[i]) begin
            up &= psdu[i] == CTXT_FILL_HIGH;
            dn &= psdu[i] == CTXT_FILL_LOW;
        end
        wr(CTXT_ADDR_UNLOCK, CTXT_UNLOCK_KEY1);
        wr(CTXT_ADDR_UNLOCK, 8'h47);
        wr(CTXT_ADDR_UNLOCK, CTXT_UNLOCK_KEY2);
        wr(CTXT_ADDR_COMMAND, CTXT_CMD_PLL_ON);
        for (k = 0; k < 200 && irq_q !== 1'b1; k++) @(negedge clk);
        chk(irq_q, 1'b1);
        if (k == 200) stop_test();
        rd(CTXT_ADDR_IRQ_STATUS, 8'h01);
        wr(CTXT_ADDR_COMMAND, CTXT_CMD_TX_START);
        rd(CTXT_ADDR_STATE, CTXT_ST_BUSY_TX);
        chk(test_on_q, 1'b0);
        wr(CTXT_ADDR_UNLOCK, CTXT_UNLOCK_KEY1);
        wr(CTXT_ADDR_UNLOCK, CTXT_UNLOCK_KEY2);
        @(negedge clk);
        chk(test_on_q, 1'b1);
        chk(cw_mode_q, cw);
        chk(tone_up_q, cw && up);
        chk(tone_down_q, cw && dn);
        for (k = 0; k < 20000 && got.size() < 2 * len + 3; k++) @(negedge clk);
        if (k == 20000) begin
            error_cnt++;
            stop_test();
        end
        for (k = 0; k < 2 * len + 3; k++) chk(got[k], psdu[k % len]);
        wr(CTXT_ADDR_UNLOCK, CTXT_UNLOCK_OFF);
        @(negedge clk);
        chk(test_on_q, 1'b0);
    endtask
    // Main sequence: pseudo-random, low tone, high tone, tone mode with random fill and neither tone side
    initial begin
        rst_b = 1'b0;
        stall = 1'b0;
        reg_we = 1'b0;
        reg_re = 1'b0;
        fb_we = 1'b0;
        reg_addr = 6'h00;
        fb_addr = 7'h00;
        reg_wdata = 8'h00;
        fb_wdata = 8'h00;
        lfsr_q = 17'h10645;
        run(1'b0, 0);
        run(1'b1, 1);
        run(1'b1, 2);
        run(1'b1, 3);
        stop_test();
    end
endmodule
bind ctxt_core ctxt_core_asserts u_chk (.clk(clk), .rst_b(rst_b), .reg_we(reg_we), .reg_re(reg_re),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .test_on_q(test_on_q), .cw_mode_q(cw_mode_q), .tone_up_q(tone_up_q), .tone_down_q(tone_down_q),
    .tx_clk(tx_clk), .tx_ready(tx_ready), .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q));
